// File: hw/iopg_top.sv
// i/o processor end of the bus priority request and grant signalling
// assumes bus pins are asynchronous; memory engine sits on clk_i
`timescale 1ns/1ps
`default_nettype none
`include "iopg_map.svh"
module iopg_top
    import iopg_pkg::*;
(
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [`IOPG_LEVELS-1:0] priority_interrupt_request_l_i,
    output logic [`IOPG_LEVELS-1:0] priority_interrupt_grant_o,
    output logic [`IOPG_LEVELS-1:0] priority_interrupt_chain_enable_o,
    output logic [`IOPG_ADDR_W-1:0] api_entry_address_o,
    output logic [`IOPG_LEVELS-1:0] api_entry_level_o,
    output logic api_entry_valid_o,
    input wire logic channel_request_l_i,
    input wire logic single_cycle_request_l_i,
    output logic channel_chain_enable_o,
    output logic channel_grant_o,
    input wire logic [`IOPG_ADDR_W-1:0] io_address_l_i,
    input wire logic add_mode_i,
    input wire logic [`IOPG_WORD_W-1:0] add_operand_mem_i,
    input wire logic [`IOPG_WORD_W-1:0] add_operand_dev_i,
    output logic add_overflow_indication_o,
    output logic io_sync_o,
    input wire logic io_transfer_instruction_i,
    input wire logic [`IOPG_WORD_W-1:0] instruction_word_i,
    output logic [5:0] device_select_line_o,
    output logic [1:0] subdevice_select_o,
    output logic cmd_valid_o,
    input wire logic cmd_ready_i,
    output logic [`IOPG_CMD_W-1:0] cmd_data_o
);
    localparam int RAW_W = `IOPG_LEVELS + 2 + `IOPG_ADDR_W;

    // channel and single cycle pins to a transfer kind
    function automatic iopg_xfer_type decode_xfer(input logic ch, input logic sing);
        iopg_xfer_type k;
        k = IOPG_XFER_NONE;
        if (ch && sing) begin
            k = IOPG_XFER_SINGLE_IN;
        end else if (ch) begin
            k = IOPG_XFER_MULTI;
        end else if (sing) begin
            k = IOPG_XFER_SINGLE_OUT;
        end
        return k;
    endfunction : decode_xfer

    logic [RAW_W-1:0] raw;
    logic [RAW_W-1:0] sync1;
    logic [RAW_W-1:0] sync2;
    logic [RAW_W-1:0] sync3;
    logic [RAW_W-1:0] stable;
    logic [`IOPG_LEVELS-1:0] api_req;
    logic ch_req;
    logic sing_req;
    logic [`IOPG_ADDR_W-1:0] bus_addr;
    logic [`IOPG_CNT_W-1:0] sync_cnt;
    logic sync_tick;
    iopg_api_state_type api_state;
    logic [`IOPG_LEVELS-1:0] next_api_pick;
    iopg_ch_state_type ch_state;
    iopg_xfer_type ch_kind;
    iopg_xfer_type live_kind;
    logic [`IOPG_CNT_W-1:0] ch_cnt;
    logic [1:0] phase;
    logic buf_in_valid;
    logic buf_in_ready;
    logic [`IOPG_WORD_W:0] raw_sum;
    logic [`IOPG_WORD_W-1:0] oc_sum;
    logic oc_overflow;

    // pins are low true on the bus, flip them here
    assign raw = ~{priority_interrupt_request_l_i, channel_request_l_i, single_cycle_request_l_i, io_address_l_i};

    // three stage pin synchronisers
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
        end else begin
            sync1 <= raw;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // a change counts once stages two and three agree
    for (genvar g = 0; g < RAW_W; g++) begin : g_filter
        always_ff @(posedge clk_i) begin
            if (srst_i) begin
                stable[g] <= 1'b0;
            end else if (sync2[g] == sync3[g]) begin
                stable[g] <= sync3[g];
            end
        end
    end

    assign api_req = stable[RAW_W-1 -: `IOPG_LEVELS];
    assign ch_req = stable[`IOPG_ADDR_W+1];
    assign sing_req = stable[`IOPG_ADDR_W];
    assign bus_addr = stable[`IOPG_ADDR_W-1:0];

    // i/o sync divider, one pulse per sync period
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sync_cnt <= '0;
        end else if (sync_tick) begin
            sync_cnt <= '0;
        end else begin
            sync_cnt <= sync_cnt + 8'h01;
        end
    end
    assign sync_tick = (sync_cnt == 8'(`IOPG_SYNC_CYC - 1));
    assign io_sync_o = sync_tick;

    // chain heads are steady levels, high from reset on
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            priority_interrupt_chain_enable_o <= '1;
            channel_chain_enable_o <= 1'b1;
        end else begin
            priority_interrupt_chain_enable_o <= '1;
            channel_chain_enable_o <= 1'b1;
        end
    end

    // pick the lowest numbered pending level
    always_comb begin
        next_api_pick = '0;
        for (int i = `IOPG_LEVELS - 1; i >= 0; i--) begin
            if (api_req[i]) begin
                next_api_pick = '0;
                next_api_pick[i] = 1'b1;
            end
        end
    end

    // interrupt arbiter: grant at sync, hold until request drops
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            api_state <= IOPG_API_IDLE;
            priority_interrupt_grant_o <= '0;
        end else begin
            case (api_state)
                IOPG_API_IDLE: begin
                    if (sync_tick && api_req != '0) begin
                        priority_interrupt_grant_o <= next_api_pick;
                        api_state <= IOPG_API_GRANT;
                    end
                end
                IOPG_API_GRANT: begin
                    if ((api_req & priority_interrupt_grant_o) == '0) begin
                        priority_interrupt_grant_o <= '0;
                        api_state <= IOPG_API_IDLE;
                    end
                end
                default: begin
                    priority_interrupt_grant_o <= '0;
                    api_state <= IOPG_API_IDLE;
                end
            endcase
        end
    end

    // entry address taken once the granted device has settled
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            api_entry_address_o <= '0;
            api_entry_level_o <= '0;
            api_entry_valid_o <= 1'b0;
        end else begin
            api_entry_valid_o <= 1'b0;
            if (api_state == IOPG_API_GRANT && sync_tick) begin
                api_entry_address_o <= bus_addr;
                api_entry_level_o <= priority_interrupt_grant_o;
                api_entry_valid_o <= 1'b1;
            end
        end
    end

    // live decode of the two request pins
    assign live_kind = decode_xfer(ch_req, sing_req);

    // ones complement sum with end around carry
    assign raw_sum = {1'b0, add_operand_mem_i} + {1'b0, add_operand_dev_i};
    assign oc_sum = raw_sum[`IOPG_WORD_W-1:0] + {{(`IOPG_WORD_W-1){1'b0}}, raw_sum[`IOPG_WORD_W]};
    assign oc_overflow = (add_operand_mem_i[`IOPG_WORD_W-1] == add_operand_dev_i[`IOPG_WORD_W-1])
                         && (oc_sum[`IOPG_WORD_W-1] != add_operand_mem_i[`IOPG_WORD_W-1]);

    // channel sequencer; a full buffer holds off the grant
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ch_state <= IOPG_CH_IDLE;
            ch_kind <= IOPG_XFER_NONE;
            channel_grant_o <= 1'b0;
            ch_cnt <= '0;
            phase <= 2'h0;
        end else begin
            case (ch_state)
                IOPG_CH_IDLE: begin
                    if (sync_tick && live_kind != IOPG_XFER_NONE && buf_in_ready) begin
                        channel_grant_o <= 1'b1;
                        ch_kind <= live_kind;
                        ch_cnt <= '0;
                        ch_state <= IOPG_CH_GRANT;
                    end
                end
                IOPG_CH_GRANT: begin
                    if (ch_cnt == 8'(`IOPG_SETTLE_CYC + 3)) begin
                        ch_state <= IOPG_CH_PUSH;
                    end else begin
                        ch_cnt <= ch_cnt + 8'h01;
                    end
                end
                IOPG_CH_PUSH: begin
                    if (buf_in_ready) begin
                        channel_grant_o <= 1'b0;
                        ch_cnt <= '0;
                        phase <= 2'h1;
                        ch_state <= (ch_kind == IOPG_XFER_MULTI) ? IOPG_CH_CYCLE : IOPG_CH_RELEASE;
                    end
                end
                IOPG_CH_CYCLE: begin
                    if (ch_cnt == 8'(`IOPG_CYCLE_CYC - 1)) begin
                        ch_cnt <= '0;
                        if (phase == 2'h3) begin
                            ch_state <= IOPG_CH_RELEASE;
                        end else begin
                            phase <= phase + 2'h1;
                        end
                    end else begin
                        ch_cnt <= ch_cnt + 8'h01;
                    end
                end
                IOPG_CH_RELEASE: begin
                    if (!ch_req && !sing_req) begin
                        ch_state <= IOPG_CH_IDLE;
                    end
                end
                default: begin
                    channel_grant_o <= 1'b0;
                    ch_state <= IOPG_CH_IDLE;
                end
            endcase
        end
    end

    // overflow only in the third add cycle, otherwise low
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            add_overflow_indication_o <= 1'b0;
        end else begin
            add_overflow_indication_o <= (ch_state == IOPG_CH_CYCLE) && (phase == 2'h3) && add_mode_i && oc_overflow;
        end
    end

    assign buf_in_valid = (ch_state == IOPG_CH_PUSH);

    // command buffer toward the memory engine
    iopg_buf u_buf (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .in_valid_i(buf_in_valid),
        .in_ready_o(buf_in_ready),
        .in_data_i({ch_kind, bus_addr}),
        .out_valid_o(cmd_valid_o),
        .out_ready_i(cmd_ready_i),
        .out_data_o(cmd_data_o)
    );

    // select fields latched at each i/o transfer instruction
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            device_select_line_o <= '0;
            subdevice_select_o <= '0;
        end else if (io_transfer_instruction_i) begin
            device_select_line_o <= instruction_word_i[`IOPG_DSEL_LSB +: 6];
            // subdevice from bits 12 and 13
            subdevice_select_o <= instruction_word_i[`IOPG_SUB_LSB +: 2];
        end
    end
endmodule : iopg_top
`default_nettype wire

// File: hw/iopg_map.svh
// constants of the i/o bus priority request and grant block
// assumes a single 125 mhz clock and bus pins that arrive asynchronously
// Summary of operation
// - Four interrupt request levels, zero to three, are accepted and level zero wins over the rest.
// - In the third cycle of an add to memory, overflow is driven when like-signed addends give a sum of other sign.
// - The processor drives the channel chain enable as a steady level at the head of the chain.
// - The processor asserts the channel grant when it acknowledges a pending channel request.
// - Channel and single cycle requests decode as none, single out, multicycle, or single in.
// - A channel request without single cycle request is a multicycle, increment or add to memory transfer.
// - Six device select lines come from the instruction, the first from instruction bit 6.
// - Device and subdevice select fields from instruction bits 6 to 13 go on the bus for an i/o transfer.
`ifndef IOPG_MAP_SVH
`define IOPG_MAP_SVH
`define IOPG_CLK_MHZ 125
`define IOPG_SYNC_NS 1000
`define IOPG_SYNC_CYC ((`IOPG_SYNC_NS * `IOPG_CLK_MHZ) / 1000)
`define IOPG_SETTLE_NS 250
`define IOPG_SETTLE_CYC (((`IOPG_SETTLE_NS * `IOPG_CLK_MHZ) + 999) / 1000)
`define IOPG_CYCLE_NS 1000
`define IOPG_CYCLE_CYC ((`IOPG_CYCLE_NS * `IOPG_CLK_MHZ) / 1000)
`define IOPG_LEVELS 4
`define IOPG_ADDR_W 15
`define IOPG_WORD_W 18
`define IOPG_DSEL_LSB 6
`define IOPG_SUB_LSB 12
`define IOPG_CMD_W 19
`define IOPG_CNT_W 8
`endif

// File: hw/iopg_pkg.sv
// types of the i/o bus priority request and grant block
// assumes iopg_map.svh is on the include path
package iopg_pkg;
    // decoded channel transfer kind, one-hot
    typedef enum logic [3:0] {
        IOPG_XFER_NONE = 4'h1,
        IOPG_XFER_SINGLE_OUT = 4'h2,
        IOPG_XFER_MULTI = 4'h4,
        IOPG_XFER_SINGLE_IN = 4'h8
    } iopg_xfer_type;
    // channel sequencer states
    typedef enum logic [4:0] {
        IOPG_CH_IDLE = 5'h01,
        IOPG_CH_GRANT = 5'h02,
        IOPG_CH_PUSH = 5'h04,
        IOPG_CH_CYCLE = 5'h08,
        IOPG_CH_RELEASE = 5'h10
    } iopg_ch_state_type;
    // interrupt level arbiter states
    typedef enum logic [1:0] {
        IOPG_API_IDLE = 2'h1,
        IOPG_API_GRANT = 2'h2
    } iopg_api_state_type;
endpackage : iopg_pkg

// File: hw/iopg_buf.sv
// two-entry buffer for channel transfer commands
// assumes one clock domain; the drain side may stall at will
`timescale 1ns/1ps
`default_nettype none
`include "iopg_map.svh"
module iopg_buf (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [`IOPG_CMD_W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [`IOPG_CMD_W-1:0] out_data_o
);
    logic [`IOPG_CMD_W-1:0] slot [2];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;
    logic push;
    logic pop;

    // full and empty straight from the count
    assign in_ready_o = (count != 2'h2);
    assign out_valid_o = (count != 2'h0);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // storage writes, no reset needed on data
    always_ff @(posedge clk_i) begin
        if (push) begin
            slot[wr_ptr] <= in_data_i;
        end
    end

    // pointers and occupancy
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr <= ~wr_ptr;
            end
            if (pop) begin
                rd_ptr <= ~rd_ptr;
            end
            if (push && !pop) begin
                count <= count + 2'h1;
            end else if (pop && !push) begin
                count <= count - 2'h1;
            end
        end
    end

    // registered read data, follows the head entry
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            out_data_o <= '0;
        end else if (pop && count == 2'h2) begin
            out_data_o <= slot[~rd_ptr];
        end else if (push && (count == 2'h0 || (pop && count == 2'h1))) begin
            out_data_o <= in_data_i;
        end else if (count != 2'h0) begin
            out_data_o <= slot[rd_ptr];
        end
    end
endmodule : iopg_buf
`default_nettype wire

// File: tb/iopg_chk.sv
// port assertions for the priority request and grant block
// assumes it is bound onto iopg_top and shares its clock and reset
`timescale 1ns/1ps
`default_nettype none
`include "iopg_map.svh"
module iopg_chk (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic [`IOPG_LEVELS-1:0] priority_interrupt_grant_o,
    input wire logic [`IOPG_LEVELS-1:0] priority_interrupt_chain_enable_o,
    input wire logic [`IOPG_LEVELS-1:0] api_entry_level_o,
    input wire logic api_entry_valid_o,
    input wire logic channel_chain_enable_o,
    input wire logic channel_grant_o,
    input wire logic add_mode_i,
    input wire logic [`IOPG_WORD_W-1:0] add_operand_mem_i,
    input wire logic [`IOPG_WORD_W-1:0] add_operand_dev_i,
    input wire logic add_overflow_indication_o,
    input wire logic io_sync_o,
    input wire logic io_transfer_instruction_i,
    input wire logic [`IOPG_WORD_W-1:0] instruction_word_i,
    input wire logic [5:0] device_select_line_o,
    input wire logic [1:0] subdevice_select_o
);
    logic [18:0] raw_sum;
    logic [17:0] oc_sum;
    logic sign_flip;
    logic ovf_cause;
    logic [7:0] grant_len;
    // ones complement add, end-around carry folded back in
    assign raw_sum = {1'b0, add_operand_mem_i} + {1'b0, add_operand_dev_i};
    assign oc_sum = raw_sum[17:0] + {17'h0, raw_sum[18]};
    assign sign_flip = (add_operand_mem_i[17] == add_operand_dev_i[17]) && (oc_sum[17] != add_operand_mem_i[17]);
    assign ovf_cause = add_mode_i && sign_flip;
    // channel grant length; wraps past 255, longer than any legal grant
    always_ff @(posedge clk_i) begin
        if (srst_i || !channel_grant_o) begin
            grant_len <= 8'h00;
        end else begin
            grant_len <= grant_len + 8'h01;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    chain_heads_a: assert property (priority_interrupt_chain_enable_o == 4'hf)
        else $error("level chain enable dropped");
    channel_head_a: assert property (channel_chain_enable_o)
        else $error("channel chain enable dropped");
    grant_onehot_a: assert property ($onehot0(priority_interrupt_grant_o))
        else $error("more than one level granted");
    grant_sync_a: assert property ($rose(|priority_interrupt_grant_o) |-> $past(io_sync_o))
        else $error("level grant not after sync");
    grant_hold_a: assert property ((|priority_interrupt_grant_o) && $past(|priority_interrupt_grant_o)
        |-> $stable(priority_interrupt_grant_o)) else $error("level grant changed while held");
    chan_sync_a: assert property ($rose(channel_grant_o) |-> $past(io_sync_o))
        else $error("channel grant not after sync");
    chan_len_a: assert property ($fell(channel_grant_o) |-> grant_len >= 8'h23)
        else $error("channel grant too short");
    ovf_cause_a: assert property (add_overflow_indication_o |-> $past(ovf_cause))
        else $error("overflow without like-sign flip");
    dsel_load_a: assert property (io_transfer_instruction_i |=> {subdevice_select_o, device_select_line_o}
        == $past(instruction_word_i[13:6])) else $error("select lines wrong");
    entry_valid_a: assert property (api_entry_valid_o |-> $past(io_sync_o)
        && api_entry_level_o == $past(priority_interrupt_grant_o)) else $error("entry sample mistimed");
endmodule : iopg_chk
`default_nettype wire

// File: tb/iopg_ctl_model.sv
// far side: one controller per level plus one channel device
// assumes released address lines float high through pull-ups
`timescale 1ns/1ps
`default_nettype none
module iopg_ctl_model #(
    parameter logic [5:0] OWN_CODE = 6'h2a,
    parameter logic [14:0] ENTRY_BASE = 15'h0040
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic io_sync_i,
    input wire logic [3:0] api_grant_i,
    input wire logic [3:0] api_enable_i,
    input wire logic ch_enable_i,
    input wire logic ch_grant_i,
    input wire logic overflow_i,
    input wire logic [5:0] dsel_i,
    input wire logic [3:0] want_api_i,
    input wire logic want_ch_i,
    input wire logic want_sing_i,
    input wire logic [14:0] ch_addr_i,
    input wire logic ovf_clr_i,
    output logic [3:0] api_req_l_o,
    output logic ch_req_l_o,
    output logic sing_req_l_o,
    output logic [14:0] addr_l_o,
    output logic ch_enable_o,
    output logic overflow_seen_o,
    output logic selected_o
);
    logic [3:0] api_pend;
    logic ch_pend;
    logic sing_pend;
    // raise at sync, drop at sync once granted
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            api_pend <= 4'h0;
            api_req_l_o <= 4'hf;
        end else begin
            for (int k = 0; k < 4; k++) begin
                if (want_api_i[k]) begin
                    api_pend[k] <= 1'b1;
                end
                if (!api_req_l_o[k] && api_grant_i[k] && io_sync_i) begin
                    api_req_l_o[k] <= 1'b1;
                end else if (api_pend[k] && io_sync_i && api_enable_i[k] && api_req_l_o[k] && !api_grant_i[k]) begin
                    api_req_l_o[k] <= 1'b0;
                    api_pend[k] <= 1'b0;
                end
            end
        end
    end
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ch_req_l_o <= 1'b1;
            sing_req_l_o <= 1'b1;
            ch_pend <= 1'b0;
            sing_pend <= 1'b0;
        end else if (ch_grant_i) begin
            ch_req_l_o <= 1'b1;
            sing_req_l_o <= 1'b1;
        end else if (io_sync_i && ch_enable_i && (ch_pend || sing_pend) && ch_req_l_o && sing_req_l_o) begin
            ch_req_l_o <= !ch_pend;
            sing_req_l_o <= !sing_pend;
            ch_pend <= 1'b0;
            sing_pend <= 1'b0;
        end else begin
            ch_pend <= ch_pend | want_ch_i;
            sing_pend <= sing_pend | want_sing_i;
        end
    end
    // address only while granted, lines idle high
    always_comb begin
        addr_l_o = 15'h7fff;
        for (int k = 3; k >= 0; k--) begin
            if (api_grant_i[k]) begin
                addr_l_o = ~(ENTRY_BASE + 15'(k));
            end
        end
        if (ch_grant_i) begin
            addr_l_o = ~ch_addr_i;
        end
    end
    // latch overflow for the add in progress
    always_ff @(posedge clk_i) begin
        if (srst_i || ovf_clr_i) begin
            overflow_seen_o <= 1'b0;
        end else if (overflow_i) begin
            overflow_seen_o <= 1'b1;
        end
    end
    // chain passes on unless channel request is low; own code decode
    assign ch_enable_o = ch_enable_i && ch_req_l_o;
    assign selected_o = (dsel_i == OWN_CODE);
endmodule : iopg_ctl_model
`default_nettype wire

// File: tb/tb_top.sv
// bench for iopg_top with a controller model and a bound checker
// assumes map header and package compile first
`timescale 1ns/1ps
`default_nettype none
`include "iopg_map.svh"
module tb_top;
    import iopg_pkg::*;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [3:0] rq_l, gr, en, lvl, want = 4'h0;
    logic [14:0] eaddr, addr_l, caddr = 15'h0;
    logic [17:0] opm = 18'h0, opd = 18'h0, iword = 18'h0;
    logic [18:0] cdata;
    logic [5:0] dsel;
    logic [1:0] sub;
    logic ch_l, sg_l, chen, chgr, ev, ovf, sync, cval, sel, seen;
    logic addm = 1'b0, io_transfer_instruction = 1'b0, crdy = 1'b0, wch = 1'b0, wsg = 1'b0, oclr = 1'b0;
    int fail_count = 0;
    int n_tests = 0;
    // 125 mhz clock
    always #4 clk_i = ~clk_i;
    iopg_top dut (.clk_i(clk_i), .srst_i(srst_i), .priority_interrupt_request_l_i(rq_l),
        .priority_interrupt_grant_o(gr), .priority_interrupt_chain_enable_o(en), .api_entry_address_o(eaddr),
        .api_entry_level_o(lvl), .api_entry_valid_o(ev), .channel_request_l_i(ch_l), .single_cycle_request_l_i(sg_l),
        .channel_chain_enable_o(chen), .channel_grant_o(chgr), .io_address_l_i(addr_l), .add_mode_i(addm),
        .add_operand_mem_i(opm), .add_operand_dev_i(opd), .add_overflow_indication_o(ovf), .io_sync_o(sync),
        .io_transfer_instruction_i(io_transfer_instruction), .instruction_word_i(iword), .device_select_line_o(dsel),
        .subdevice_select_o(sub), .cmd_valid_o(cval), .cmd_ready_i(crdy), .cmd_data_o(cdata));
    iopg_ctl_model u_ctl (.clk_i(clk_i), .srst_i(srst_i), .io_sync_i(sync), .api_grant_i(gr), .api_enable_i(en),
        .ch_enable_i(chen), .ch_grant_i(chgr), .overflow_i(ovf), .dsel_i(dsel), .want_api_i(want), .want_ch_i(wch),
        .want_sing_i(wsg), .ch_addr_i(caddr), .ovf_clr_i(oclr), .api_req_l_o(rq_l), .ch_req_l_o(ch_l),
        .sing_req_l_o(sg_l), .addr_l_o(addr_l), .ch_enable_o(), .overflow_seen_o(seen), .selected_o(sel));
    task step(int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : step
    task chk(logic [31:0] seen_v, logic [31:0] exp_v);
        n_tests++;
        if (seen_v !== exp_v) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen_v, exp_v);
        end
    endtask : chk
    function automatic logic pick(int w);
        case (w)
            0: return chgr;
            1: return cval;
            2: return ev;
            default: return |gr;
        endcase
    endfunction : pick
    // bounded wait for a design handshake
    task automatic wait_hi(int w);
        int i;
        i = 0;
        while (pick(w) !== 1'b1 && i < 2000) begin
            step(1);
            i++;
        end
        chk(32'(pick(w)), 32'h1);
    endtask : wait_hi
    task close_out();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out
    task t_reset();
        chk({en, chen, gr, chgr, cval}, {4'hf, 1'b1, 4'h0, 1'b0, 1'b0});
        $display("reset test done");
    endtask : t_reset
    // two levels posted at the same sync, served in level order
    task t_api(int lo, int hi);
        int lv[2];
        lv = '{lo, hi};
        want = 4'((1 << lo) | (1 << hi));
        step(1);
        want = 4'h0;
        for (int j = 0; j < 2; j++) begin
            wait_hi(3);
            chk(gr, 1 << lv[j]);
            wait_hi(2);
            chk({lvl, eaddr}, {4'(1 << lv[j]), 15'h0040 + 15'(lv[j])});
            step(20);
        end
        chk(gr, 4'h0);
        $display("level test done");
    endtask : t_api
    // one channel transfer of the given kind, drained at once
    task t_chan(logic c, logic s, logic [17:0] m, logic [17:0] d, logic [3:0] kind, logic ov);
        caddr = {11'h2a5, kind};
        addm = (kind == IOPG_XFER_MULTI);
        opm = m;
        opd = d;
        oclr = 1'b1;
        wch = c;
        wsg = s;
        step(1);
        {oclr, wch, wsg} = 3'h0;
        wait_hi(0);
        wait_hi(1);
        chk(cdata, {kind, 11'h2a5, kind});
        crdy = 1'b1;
        step(1);
        crdy = 1'b0;
        // overflow must stay quiet through phases one and two
        if (kind == IOPG_XFER_MULTI) begin
            step(2 * `IOPG_CYCLE_CYC - 4);
            chk(seen, 1'b0);
            step(`IOPG_CYCLE_CYC + `IOPG_SYNC_CYC + 4);
        end
        chk(seen, ov);
        step(`IOPG_SYNC_CYC);
        $display("channel test done");
    endtask : t_chan
    // receiver stalls: third request refused until a word drains
    task t_buffer();
        addm = 1'b0;
        for (int j = 0; j < 3; j++) begin
            caddr = 15'h0100 + 15'(j);
            wsg = 1'b1;
            step(1);
            wsg = 1'b0;
            if (j < 2) begin
                wait_hi(0);
                step(40);
            end
        end
        step(300);
        chk(chgr, 1'b0);
        for (int j = 0; j < 3; j++) begin
            wait_hi(1);
            chk(cdata, {IOPG_XFER_SINGLE_OUT, 15'h0100 + 15'(j)});
            crdy = 1'b1;
            step(1);
            crdy = 1'b0;
            // let an edge pass with ready low before the next drain
            step(1);
        end
        step(2);
        chk(cval, 1'b0);
        $display("buffer test done");
    endtask : t_buffer
    task t_dsel();
        logic [5:0] code;
        for (int j = 0; j < 2; j++) begin
            code = j ? 6'h15 : 6'h2a;
            iword = {4'h0, 2'(j + 1), code, 6'h11};
            io_transfer_instruction = 1'b1;
            step(1);
            io_transfer_instruction = 1'b0;
            step(1);
            chk({sub, dsel}, {2'(j + 1), code});
            chk(sel, j == 0);
        end
        $display("select test done");
    endtask : t_dsel
    // main sequence
    initial begin
        step(10);
        srst_i = 1'b0;
        t_reset();
        t_api(1, 3);
        t_api(0, 2);
        t_chan(1'b0, 1'b1, 18'h0, 18'h0, IOPG_XFER_SINGLE_OUT, 1'b0);
        t_chan(1'b1, 1'b1, 18'h0, 18'h0, IOPG_XFER_SINGLE_IN, 1'b0);
        t_chan(1'b1, 1'b0, 18'h1ffff, 18'h00001, IOPG_XFER_MULTI, 1'b1);
        t_chan(1'b1, 1'b0, 18'h00005, 18'h3fff0, IOPG_XFER_MULTI, 1'b0);
        t_buffer();
        t_dsel();
        close_out();
    end
    // watchdog well beyond the expected run
    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        close_out();
    end
endmodule : tb_top
bind iopg_top iopg_chk u_chk (.clk_i(clk_i), .srst_i(srst_i), .priority_interrupt_grant_o(priority_interrupt_grant_o),
    .priority_interrupt_chain_enable_o(priority_interrupt_chain_enable_o), .api_entry_level_o(api_entry_level_o),
    .api_entry_valid_o(api_entry_valid_o), .channel_chain_enable_o(channel_chain_enable_o),
    .channel_grant_o(channel_grant_o), .add_mode_i(add_mode_i), .add_operand_mem_i(add_operand_mem_i),
    .add_operand_dev_i(add_operand_dev_i), .add_overflow_indication_o(add_overflow_indication_o),
    .io_sync_o(io_sync_o), .io_transfer_instruction_i(io_transfer_instruction_i),
    .instruction_word_i(instruction_word_i), .device_select_line_o(device_select_line_o),
    .subdevice_select_o(subdevice_select_o));
`default_nettype wire
